// ---- hw/flash_prog_pkg.sv ----
// Constants, register map and state codes of the buffered flash programmer.
package flash_prog_pkg;
	// ****************************************************************
	// Widths and buffer
	// ****************************************************************
	localparam int AW        = 24;
	localparam int DW        = 16;
	localparam int IW        = 5;
	localparam int BUF_DEPTH = 32;
	localparam int BLOCK_LSB = 16;
	localparam int ALIGN_W   = 5;
	localparam int SYNC_CYC  = 2;
	// ****************************************************************
	// Flash command codes and status fields
	// ****************************************************************
	localparam logic [7:0]    CMD_LOAD    = 8'hE8;
	localparam logic [7:0]    CMD_CONFIRM = 8'hD0;
	localparam logic [IW-1:0] CNT_MAX_X16 = 5'h0F;
	localparam logic [IW-1:0] CNT_MAX_X8  = 5'h1F;
	localparam int            AVAIL_BIT   = 7;
	localparam int            READY_BIT   = 7;
	localparam logic [7:0]    ERR_MASK    = 8'h3A;
	// ****************************************************************
	// Pin timing
	// ****************************************************************
	localparam int CLK_PS      = 5000;
	localparam int T_SETUP_NS  = 10;
	localparam int T_WE_NS     = 70;
	localparam int T_OE_NS     = 100;
	localparam int T_RECOV_NS  = 30;
	localparam int SETUP_CYC   = (T_SETUP_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int WE_CYC      = (T_WE_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int OE_CYC      = (T_OE_NS * 1000 + CLK_PS - 1) / CLK_PS + SYNC_CYC;
	localparam int RECOV_CYC   = (T_RECOV_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam logic [7:0] SETUP_LD = 8'(SETUP_CYC - 1);
	localparam logic [7:0] WE_LD    = 8'(WE_CYC - 1);
	localparam logic [7:0] OE_LD    = 8'(OE_CYC - 1);
	localparam logic [7:0] RECOV_LD = 8'(RECOV_CYC - 1);
	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [7:0] REG_CTRL    = 8'h00;
	localparam logic [7:0] REG_START   = 8'h04;
	localparam logic [7:0] REG_COUNT   = 8'h08;
	localparam logic [7:0] REG_STATUS  = 8'h0C;
	localparam int         BUF_SEL_BIT = 7;
	localparam int         CTRL_GO     = 0;
	localparam int         CTRL_X8     = 1;
	localparam int         STS_SR_LSB  = 8;
	localparam int         STS_XSR_LSB = 16;
	// ****************************************************************
	// State codes
	// ****************************************************************
	typedef enum logic [3:0] {
		ST_IDLE  = 4'h0,
		ST_CLR   = 4'h1,
		ST_LOAD  = 4'h2,
		ST_XPOLL = 4'h3,
		ST_COUNT = 4'h4,
		ST_DATA  = 4'h5,
		ST_CONF  = 4'h6,
		ST_SPOLL = 4'h7,
		ST_ARRAY = 4'h8
	} state_t;
	typedef enum logic [1:0] {
		PH_IDLE   = 2'h0,
		PH_SETUP  = 2'h1,
		PH_STROBE = 2'h2,
		PH_RECOV  = 2'h3
	} phase_t;
endpackage : flash_prog_pkg

// ---- hw/pin_sync.sv ----
// Two-stage synchroniser for the flash data pins.
`timescale 1ns/10ps
module pin_sync (
	input  wire logic                          clk_i,
	input  wire logic [flash_prog_pkg::DW-1:0] d_i,
	output logic      [flash_prog_pkg::DW-1:0] q_o
);
	logic [flash_prog_pkg::DW-1:0] meta_r;
	logic [flash_prog_pkg::DW-1:0] q_r;
	genvar g;
	generate
		for (g = 0; g < flash_prog_pkg::DW; g++) begin : g_bit
			always_ff @(posedge clk_i) begin
				meta_r[g] <= d_i[g];
				q_r[g]    <= meta_r[g];
			end
		end
	endgenerate
	assign q_o = q_r;
endmodule : pin_sync

// ---- hw/flash_bus_cycle.sv ----
// One strobed read or write cycle on the flash pins.
`timescale 1ns/10ps
module flash_bus_cycle (
	input  wire logic                          clk_i,
	input  wire logic                          rst_i,
	input  wire logic                          req_i,
	input  wire logic                          we_i,
	input  wire logic [flash_prog_pkg::AW-1:0] addr_i,
	input  wire logic [flash_prog_pkg::DW-1:0] wdata_i,
	input  wire logic [flash_prog_pkg::DW-1:0] dq_sync_i,
	output logic                               busy_o,
	output logic                               done_o,
	output logic      [flash_prog_pkg::DW-1:0] rdata_o,
	output logic                               ce_n_o,
	output logic                               we_n_o,
	output logic                               oe_n_o,
	output logic      [flash_prog_pkg::AW-1:0] addr_o,
	output logic      [flash_prog_pkg::DW-1:0] dq_o,
	output logic                               dq_oe_o
);
	flash_prog_pkg::phase_t        phase_r;
	flash_prog_pkg::phase_t        phase_nxt;
	logic [7:0]                    cnt_r;
	logic [7:0]                    cnt_nxt;
	logic                          we_r;
	logic                          done_r;
	logic                          ce_n_r;
	logic                          we_n_r;
	logic                          oe_n_r;
	logic                          dq_oe_r;
	logic [flash_prog_pkg::AW-1:0] addr_r;
	logic [flash_prog_pkg::DW-1:0] dq_r;
	logic [flash_prog_pkg::DW-1:0] rdata_r;
	logic                          zero;
	logic                          take;
	assign zero = (cnt_r == 8'h00);
	assign take = req_i && (phase_r == flash_prog_pkg::PH_IDLE);
	always_comb begin
		phase_nxt = phase_r;
		cnt_nxt   = zero ? cnt_r : cnt_r - 8'h01;
		case (phase_r)
			flash_prog_pkg::PH_IDLE: if (req_i) begin
				phase_nxt = flash_prog_pkg::PH_SETUP;
				cnt_nxt   = flash_prog_pkg::SETUP_LD;
			end
			flash_prog_pkg::PH_SETUP: if (zero) begin
				phase_nxt = flash_prog_pkg::PH_STROBE;
				cnt_nxt   = we_r ? flash_prog_pkg::WE_LD : flash_prog_pkg::OE_LD;
			end
			flash_prog_pkg::PH_STROBE: if (zero) begin
				phase_nxt = flash_prog_pkg::PH_RECOV;
				cnt_nxt   = flash_prog_pkg::RECOV_LD;
			end
			flash_prog_pkg::PH_RECOV: if (zero) begin
				phase_nxt = flash_prog_pkg::PH_IDLE;
			end
			default: phase_nxt = flash_prog_pkg::PH_IDLE;
		endcase
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			phase_r <= flash_prog_pkg::PH_IDLE;
			cnt_r   <= 8'h00;
			done_r  <= 1'b0;
			ce_n_r  <= 1'b1;
			we_n_r  <= 1'b1;
			oe_n_r  <= 1'b1;
			dq_oe_r <= 1'b0;
		end else begin
			phase_r <= phase_nxt;
			cnt_r   <= cnt_nxt;
			done_r  <= (phase_r == flash_prog_pkg::PH_RECOV) && zero;
			ce_n_r  <= (phase_nxt == flash_prog_pkg::PH_IDLE);
			we_n_r  <= !((phase_nxt == flash_prog_pkg::PH_STROBE) && (take ? we_i : we_r));
			oe_n_r  <= !((phase_nxt == flash_prog_pkg::PH_STROBE) && !(take ? we_i : we_r));
			dq_oe_r <= (phase_nxt != flash_prog_pkg::PH_IDLE) && (take ? we_i : we_r);
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			we_r    <= 1'b0;
			addr_r  <= '0;
			dq_r    <= '0;
			rdata_r <= '0;
		end else if (take) begin
			we_r   <= we_i;
			addr_r <= addr_i;
			dq_r   <= wdata_i;
		end else if ((phase_r == flash_prog_pkg::PH_STROBE) && zero && !we_r) begin
			rdata_r <= dq_sync_i;
		end
	end
	assign busy_o  = (phase_r != flash_prog_pkg::PH_IDLE);
	assign done_o  = done_r;
	assign rdata_o = rdata_r;
	assign ce_n_o  = ce_n_r;
	assign we_n_o  = we_n_r;
	assign oe_n_o  = oe_n_r;
	assign addr_o  = addr_r;
	assign dq_o    = dq_r;
	assign dq_oe_o = dq_oe_r;
endmodule : flash_bus_cycle

// ---- hw/flash_write_buffer_programmer.sv ----
// Host-side controller that programs a flash through its write buffer.
`timescale 1ns/10ps
// How it works
// [R01] Device buffer holds sixteen words, thirty-two bytes.
// [R02] Sequence opens with load code to block.
// [R03] Availability byte bit seven means buffer free.
// [R04] Unavailable buffer: reissue load, poll again.
// [R05] Word mode count code is items minus one.
// [R06] Byte mode count codes reach thirty-two bytes.
// [R07] All addresses stay inside one block range.
// [R08] Data items in order, then confirm code.
// [R09] Device shows status byte while programming.
// [R10] Status bit seven low means engine busy.
// [R11] After ready, check remaining status bits.
// [R12] Error bits four or five block loads.
// [R13] Bit four flags a program failure.
// [R14] Bits four and five flag bad sequence.
// [R15] Bits four and three flag supply lockout.
// [R16] Bits one and four flag locked block.
// [R17] Clear status after any error, then retry.
// [R18] Read-array command returns device to reads.
// [R19] Aligned full buffers program fastest.
// [R20] Confirm starts programming; bit seven rises after.
module flash_write_buffer_programmer #(
	parameter logic [7:0] CLEAR_CODE      = 8'h50,
	parameter logic [7:0] READ_ARRAY_CODE = 8'hFF
) (
	input  wire logic                          clk_i,
	input  wire logic                          rst_i,
	input  wire logic                          wb_cyc_i,
	input  wire logic                          wb_stb_i,
	input  wire logic                          wb_we_i,
	input  wire logic [7:0]                    wb_adr_i,
	input  wire logic [3:0]                    wb_sel_i,
	input  wire logic [31:0]                   wb_dat_i,
	output logic      [31:0]                   wb_dat_o,
	output logic                               wb_ack_o,
	output logic                               flash_ce_n_o,
	output logic                               flash_we_n_o,
	output logic                               flash_oe_n_o,
	output logic                               flash_byte_n_o,
	output logic      [flash_prog_pkg::AW-1:0] flash_addr_o,
	output logic      [flash_prog_pkg::DW-1:0] flash_dq_o,
	output logic                               flash_dq_oe_o,
	input  wire logic [flash_prog_pkg::DW-1:0] flash_dq_i
);
	// ****************************************************************
	// Declarations
	// ****************************************************************
	flash_prog_pkg::state_t        state_r;
	flash_prog_pkg::state_t        state_nxt;
	logic [flash_prog_pkg::IW-1:0] idx_r;
	logic [flash_prog_pkg::IW-1:0] idx_nxt;
	logic                          wait_r;
	logic                          x8_r;
	logic [flash_prog_pkg::AW-1:0] start_r;
	logic [flash_prog_pkg::IW-1:0] count_r;
	logic [flash_prog_pkg::DW-1:0] buf_r [flash_prog_pkg::BUF_DEPTH];
	logic                          flash_err_r;
	logic                          refused_r;
	logic                          aligned_r;
	logic                          done_r;
	logic [7:0]                    sr_r;
	logic [7:0]                    xsr_r;
	logic                          ack_r;
	logic [31:0]                   dat_r;
	logic                          hit;
	logic                          wr;
	logic                          open_cfg;
	logic                          sel_ctrl;
	logic                          sel_start;
	logic                          sel_count;
	logic                          sel_status;
	logic                          sel_buf;
	logic [flash_prog_pkg::IW-1:0] bidx;
	logic [31:0]                   wmask;
	logic                          new_x8;
	logic                          go;
	logic [flash_prog_pkg::IW-1:0] cnt_max;
	logic [flash_prog_pkg::AW-1:0] end_addr;
	logic                          bad;
	logic                          go_ok;
	logic [31:0]                   status_word;
	logic [31:0]                   rd_word;
	logic                          req;
	logic                          req_we;
	logic [flash_prog_pkg::AW-1:0] req_addr;
	logic [flash_prog_pkg::DW-1:0] req_wdata;
	logic [flash_prog_pkg::DW-1:0] item;
	logic                          eng_busy;
	logic                          eng_done;
	logic                          eng_take;
	logic [flash_prog_pkg::DW-1:0] eng_rdata;
	logic [flash_prog_pkg::DW-1:0] dq_sync;
	logic                          avail;
	logic                          ready;
	logic                          last;
	// ****************************************************************
	// Register bus decode
	// ****************************************************************
	assign hit        = wb_cyc_i && wb_stb_i && !ack_r;
	assign wr         = hit && wb_we_i;
	assign open_cfg   = (state_r == flash_prog_pkg::ST_IDLE);
	assign sel_ctrl   = (wb_adr_i == flash_prog_pkg::REG_CTRL);
	assign sel_start  = (wb_adr_i == flash_prog_pkg::REG_START);
	assign sel_count  = (wb_adr_i == flash_prog_pkg::REG_COUNT);
	assign sel_status = (wb_adr_i == flash_prog_pkg::REG_STATUS);
	assign sel_buf    = wb_adr_i[flash_prog_pkg::BUF_SEL_BIT];
	assign bidx       = wb_adr_i[flash_prog_pkg::IW+1:2];
	assign wmask      = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign new_x8     = wb_sel_i[0] ? wb_dat_i[flash_prog_pkg::CTRL_X8] : x8_r;
	assign go         = wr && sel_ctrl && open_cfg && wb_sel_i[0] && wb_dat_i[flash_prog_pkg::CTRL_GO];
	// ****************************************************************
	// Start checks
	// ****************************************************************
	assign cnt_max  = new_x8 ? flash_prog_pkg::CNT_MAX_X8 : flash_prog_pkg::CNT_MAX_X16; // [R05] [R06]
	assign end_addr = start_r + flash_prog_pkg::AW'(count_r); // [R07]
	assign bad      = (count_r > cnt_max) ||
		(end_addr[flash_prog_pkg::AW-1:flash_prog_pkg::BLOCK_LSB] !=
		start_r[flash_prog_pkg::AW-1:flash_prog_pkg::BLOCK_LSB]); // [R07]
	assign go_ok    = go && !bad;
	assign status_word = {8'h00, xsr_r, sr_r, 3'h0, aligned_r, refused_r, flash_err_r || refused_r, done_r, !open_cfg};
	assign rd_word  = sel_ctrl ? {30'h0, x8_r, 1'b0} :
		sel_start ? {8'h00, start_r} :
		sel_count ? {27'h0, count_r} :
		sel_status ? status_word :
		sel_buf ? {16'h0000, buf_r[bidx]} : 32'h0;
	// ****************************************************************
	// Register file
	// ****************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
			dat_r <= 32'h0;
		end else begin
			ack_r <= hit;
			dat_r <= hit ? rd_word : dat_r;
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			x8_r    <= 1'b0;
			start_r <= '0;
			count_r <= '0;
		end else if (wr && open_cfg) begin
			x8_r    <= sel_ctrl ? new_x8 : x8_r;
			start_r <= sel_start ? (start_r & ~wmask[flash_prog_pkg::AW-1:0]) |
				(wb_dat_i[flash_prog_pkg::AW-1:0] & wmask[flash_prog_pkg::AW-1:0]) : start_r;
			count_r <= (sel_count && wb_sel_i[0]) ? wb_dat_i[flash_prog_pkg::IW-1:0] : count_r;
		end
	end
	always_ff @(posedge clk_i) begin
		if (wr && open_cfg && sel_buf) begin
			buf_r[bidx] <= (buf_r[bidx] & ~wmask[flash_prog_pkg::DW-1:0]) |
				(wb_dat_i[flash_prog_pkg::DW-1:0] & wmask[flash_prog_pkg::DW-1:0]); // [R01]
		end
	end
	// ****************************************************************
	// Result flags
	// ****************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			done_r      <= 1'b0;
			refused_r   <= 1'b0;
			aligned_r   <= 1'b0;
			flash_err_r <= 1'b0;
		end else begin
			if (go) begin
				done_r    <= bad;
				refused_r <= bad;
				aligned_r <= (start_r[flash_prog_pkg::ALIGN_W-1:0] == '0) && (count_r == cnt_max); // [R19]
			end else if ((state_r == flash_prog_pkg::ST_ARRAY) && eng_done) begin
				done_r <= 1'b1;
			end
			if ((state_r == flash_prog_pkg::ST_CLR) && eng_done) begin
				flash_err_r <= 1'b0; // [R17]
			end else if ((state_r == flash_prog_pkg::ST_SPOLL) && eng_done && ready) begin
				flash_err_r <= |(eng_rdata[7:0] & flash_prog_pkg::ERR_MASK); // [R11] [R13] [R14] [R15] [R16]
			end
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sr_r  <= 8'h00;
			xsr_r <= 8'h00;
		end else begin
			sr_r  <= ((state_r == flash_prog_pkg::ST_SPOLL) && eng_done) ? eng_rdata[7:0] : sr_r; // [R09]
			xsr_r <= ((state_r == flash_prog_pkg::ST_XPOLL) && eng_done) ? eng_rdata[7:0] : xsr_r;
		end
	end
	// ****************************************************************
	// Sequencer
	// ****************************************************************
	assign avail = eng_rdata[flash_prog_pkg::AVAIL_BIT]; // [R03]
	assign ready = eng_rdata[flash_prog_pkg::READY_BIT]; // [R10]
	assign last  = (idx_r == count_r);
	always_comb begin
		state_nxt = state_r;
		idx_nxt   = idx_r;
		case (state_r)
			flash_prog_pkg::ST_IDLE: if (go_ok) begin
				state_nxt = flash_err_r ? flash_prog_pkg::ST_CLR : flash_prog_pkg::ST_LOAD; // [R12] [R17]
			end
			flash_prog_pkg::ST_CLR: if (eng_done) begin
				state_nxt = flash_prog_pkg::ST_LOAD;
			end
			flash_prog_pkg::ST_LOAD: if (eng_done) begin
				state_nxt = flash_prog_pkg::ST_XPOLL;
			end
			flash_prog_pkg::ST_XPOLL: if (eng_done) begin
				state_nxt = avail ? flash_prog_pkg::ST_COUNT : flash_prog_pkg::ST_LOAD; // [R04]
			end
			flash_prog_pkg::ST_COUNT: if (eng_done) begin
				state_nxt = flash_prog_pkg::ST_DATA;
				idx_nxt   = '0;
			end
			flash_prog_pkg::ST_DATA: if (eng_done) begin
				state_nxt = last ? flash_prog_pkg::ST_CONF : flash_prog_pkg::ST_DATA; // [R08]
				idx_nxt   = last ? idx_r : idx_r + 1'b1;
			end
			flash_prog_pkg::ST_CONF: if (eng_done) begin
				state_nxt = flash_prog_pkg::ST_SPOLL; // [R20]
			end
			flash_prog_pkg::ST_SPOLL: if (eng_done) begin
				state_nxt = ready ? flash_prog_pkg::ST_ARRAY : flash_prog_pkg::ST_SPOLL; // [R10] [R11]
			end
			flash_prog_pkg::ST_ARRAY: if (eng_done) begin
				state_nxt = flash_prog_pkg::ST_IDLE; // [R18]
			end
			default: state_nxt = flash_prog_pkg::ST_IDLE;
		endcase
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= flash_prog_pkg::ST_IDLE;
			idx_r   <= '0;
			wait_r  <= 1'b0;
		end else begin
			state_r <= state_nxt;
			idx_r   <= idx_nxt;
			wait_r  <= eng_done ? 1'b0 : (eng_take ? 1'b1 : wait_r);
		end
	end
	// ****************************************************************
	// Flash cycle requests
	// ****************************************************************
	assign req      = !open_cfg && !wait_r;
	assign eng_take = req && !eng_busy;
	assign req_we   = (state_r != flash_prog_pkg::ST_XPOLL) && (state_r != flash_prog_pkg::ST_SPOLL);
	assign req_addr = (state_r == flash_prog_pkg::ST_DATA) ?
		start_r + flash_prog_pkg::AW'(idx_r) : start_r; // [R07]
	assign item     = x8_r ? {8'h00, buf_r[idx_r][7:0]} : buf_r[idx_r];
	always_comb begin
		case (state_r)
			flash_prog_pkg::ST_CLR:   req_wdata = {8'h00, CLEAR_CODE}; // [R17]
			flash_prog_pkg::ST_LOAD:  req_wdata = {8'h00, flash_prog_pkg::CMD_LOAD}; // [R02]
			flash_prog_pkg::ST_COUNT: req_wdata = {11'h000, count_r}; // [R05] [R06]
			flash_prog_pkg::ST_DATA:  req_wdata = item; // [R08]
			flash_prog_pkg::ST_CONF:  req_wdata = {8'h00, flash_prog_pkg::CMD_CONFIRM}; // [R08]
			flash_prog_pkg::ST_ARRAY: req_wdata = {8'h00, READ_ARRAY_CODE}; // [R18]
			default:                  req_wdata = 16'h0000;
		endcase
	end
	pin_sync u_sync (
		.clk_i (clk_i),
		.d_i   (flash_dq_i),
		.q_o   (dq_sync)
	);
	flash_bus_cycle u_cycle (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.req_i     (req),
		.we_i      (req_we),
		.addr_i    (req_addr),
		.wdata_i   (req_wdata),
		.dq_sync_i (dq_sync),
		.busy_o    (eng_busy),
		.done_o    (eng_done),
		.rdata_o   (eng_rdata),
		.ce_n_o    (flash_ce_n_o),
		.we_n_o    (flash_we_n_o),
		.oe_n_o    (flash_oe_n_o),
		.addr_o    (flash_addr_o),
		.dq_o      (flash_dq_o),
		.dq_oe_o   (flash_dq_oe_o)
	);
	assign flash_byte_n_o = !x8_r;
	assign wb_ack_o       = ack_r;
	assign wb_dat_o       = dat_r;
	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence xsr_busy_s;
		(state_r == flash_prog_pkg::ST_XPOLL) && eng_done && !avail;
	endsequence
	sequence sr_ready_s;
		(state_r == flash_prog_pkg::ST_SPOLL) && eng_done && ready;
	endsequence
	a_load_code: assert property ((state_r == flash_prog_pkg::ST_LOAD) && eng_take |-> // R02
		req_we && req_wdata == {8'h00, flash_prog_pkg::CMD_LOAD})
		else $error("load command code wrong");
	a_poll_retry: assert property (xsr_busy_s |=> (state_r == flash_prog_pkg::ST_LOAD) ##1 !eng_done) // R04
		else $error("busy buffer not retried");
	a_count_word: assert property ((state_r == flash_prog_pkg::ST_COUNT) && eng_take && !x8_r |-> // R05
		req_wdata <= {11'h000, flash_prog_pkg::CNT_MAX_X16})
		else $error("word count out of range");
	a_count_byte: assert property ((state_r == flash_prog_pkg::ST_COUNT) && eng_take |-> // R06
		req_we && req_addr == start_r && req_wdata == {11'h000, count_r} && count_r <= flash_prog_pkg::CNT_MAX_X8)
		else $error("byte count code wrong");
	a_one_block: assert property ((state_r == flash_prog_pkg::ST_DATA) && eng_take |-> // R07
		req_addr[flash_prog_pkg::AW-1:flash_prog_pkg::BLOCK_LSB] ==
		start_r[flash_prog_pkg::AW-1:flash_prog_pkg::BLOCK_LSB] && idx_r <= count_r)
		else $error("data address leaves block");
	a_confirm_last: assert property ((state_r == flash_prog_pkg::ST_DATA) && eng_done && last |=> // R08
		(state_r == flash_prog_pkg::ST_CONF) && eng_take && req_wdata == {8'h00, flash_prog_pkg::CMD_CONFIRM})
		else $error("confirm missing after last item");
	a_status_poll: assert property (sr_ready_s |=> (state_r == flash_prog_pkg::ST_ARRAY) && // R11
		{8'h00, sr_r} == $past(eng_rdata) && flash_err_r == |($past(eng_rdata) & {8'h00, flash_prog_pkg::ERR_MASK}))
		else $error("status not checked at ready");
	a_clear_first: assert property (go_ok && flash_err_r |=> (state_r == flash_prog_pkg::ST_CLR) && // R17
		eng_take && req_wdata == {8'h00, CLEAR_CODE})
		else $error("error not cleared before retry");
	a_array_end: assert property ((state_r == flash_prog_pkg::ST_ARRAY) && eng_done |=> // R18
		(state_r == flash_prog_pkg::ST_IDLE) && done_r)
		else $error("read array did not finish sequence");
	a_item_step: assert property ((state_r == flash_prog_pkg::ST_DATA) && eng_done && !last |=> // R08
		(state_r == flash_prog_pkg::ST_DATA) && idx_r == $past(idx_r) + 1'b1)
		else $error("data items not sent in order");
	a_refuse_go: assert property (go && bad |=> // R07
		open_cfg && refused_r && done_r && !eng_busy)
		else $error("bad start not refused");
	a_poll_read: assert property (((state_r == flash_prog_pkg::ST_XPOLL) || // R03
		(state_r == flash_prog_pkg::ST_SPOLL)) && eng_take |-> !req_we)
		else $error("status poll is not a read");
	a_err_latch: assert property (sr_ready_s && |(eng_rdata[7:0] & flash_prog_pkg::ERR_MASK) |=> // R12
		flash_err_r)
		else $error("error status not latched");
	a_dq_release: assert property (!flash_oe_n_o |-> // R09
		!flash_dq_oe_o && !flash_ce_n_o)
		else $error("data pins driven during read");
endmodule : flash_write_buffer_programmer

// ---- verification/flash_model.sv ----
// Behavioural flash device answering the controller's pin cycles.
`timescale 1ns/10ps
module flash_model (
	input  wire logic        ce_n_i,
	input  wire logic        we_n_i,
	input  wire logic        oe_n_i,
	input  wire logic [23:0] addr_i,
	input  wire logic [15:0] dq_i,
	output logic      [15:0] dq_o
);
	logic [7:0]  sr   = 8'h80;
	logic [7:0]  err  = 8'h00;
	logic [7:0]  cnt;
	logic [15:0] mem  [0:63];
	logic [15:0] last = 16'h0000;
	logic [15:0] val;
	logic        avail;
	int          st = 0, left, busy = 0, deny = 0, n_data = 0, nw = 0, n_load = 0;
	// ********
	// Read path
	// ********
	assign val  = (st == 1) ? {8'h00, avail, 7'h00} : (st == 5) ? ((busy > 0) ? 16'h0055 : {8'h00, sr})
		: mem[addr_i[5:0]];
	assign dq_o = (ce_n_i | oe_n_i) ? ~last : val;
	always @(posedge oe_n_i) last = val;
	always @(negedge oe_n_i) if (!ce_n_i && st == 5 && busy > 0) begin
		busy--;
		if (busy == 0) sr = 8'h80 | err;
	end
	// ********
	// Write path
	// ********
	always @(posedge we_n_i) if (!ce_n_i) begin
		nw++;
		if (st == 3) begin
			mem[addr_i[5:0]] = dq_i;
			n_data++;
			left--;
			if (left == 0) st = 4;
		end else if (st == 4) begin
			st = 5;
			sr = (dq_i[7:0] == 8'hD0) ? 8'h00 : 8'hB0;
			busy = 3;
		end else if (dq_i[7:0] == 8'hE8) begin
			st = 1;
			n_load++;
			avail = (deny == 0) && (sr[5:4] == 2'h0);
			if (deny > 0) deny--;
		end else if (dq_i[7:0] == 8'h50) sr = 8'h80;
		else if (dq_i[7:0] == 8'hFF) st = 0;
		else if (st == 1 && avail) begin
			cnt = dq_i[7:0];
			left = cnt + 1;
			st = 3;
		end
	end
endmodule : flash_model

// ---- verification/testbench.sv ----
// Self-checking bench of the buffered flash programmer.
`timescale 1ns/10ps
module testbench;
	logic        clk_i = 1'h0, rst_i = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] dat = 32'h0, q, wb_dat_o;
	logic        ack, ce_n, we_n, oe_n, byte_n, dq_oe;
	logic [23:0] fa;
	logic [15:0] fdo, fdi;
	int          err_total = 0, n_tests = 0, cyc_n = 0, k, nw0;
	logic [7:0]  errs [0:4] = '{8'h10, 8'h30, 8'h18, 8'h12, 8'h00};
	flash_write_buffer_programmer uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(ack), .flash_ce_n_o(ce_n),
		.flash_we_n_o(we_n), .flash_oe_n_o(oe_n), .flash_byte_n_o(byte_n), .flash_addr_o(fa), .flash_dq_o(fdo),
		.flash_dq_oe_o(dq_oe), .flash_dq_i(fdi));
	flash_model dev (.ce_n_i(ce_n), .we_n_i(we_n), .oe_n_i(oe_n), .addr_i(fa), .dq_i(fdo), .dq_o(fdi));
	initial forever #2.5 clk_i = ~clk_i;
	always @(negedge we_n or negedge oe_n) chk(dq_oe, !we_n);
	// ********
	// Tasks
	// ********
	task end_of_test;
		if (err_total == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : end_of_test
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc <= 1'h1;
		stb <= 1'h1;
		we  <= w;
		adr <= a;
		dat <= d;
		@(posedge clk_i);
		while (ack !== 1'h1) @(posedge clk_i);
		q = wb_dat_o;
		cyc <= 1'h0;
		stb <= 1'h0;
		@(posedge clk_i);
	endtask : bus
	task poll;
		do bus(1'h0, flash_prog_pkg::REG_STATUS, 32'h0); while (q[1:0] !== 2'h2);
	endtask : poll
	task run(input logic x8, input logic [4:0] c, input logic [23:0] s, input logic [7:0] e, input int dn);
		logic [15:0] m;
		logic        al;
		m = x8 ? 16'h00FF : 16'hFFFF;
		al = (s[4:0] == 5'h00) && (c == (x8 ? 5'h1F : 5'h0F));
		dev.err = e;
		dev.deny = dn;
		dev.n_data = 0;
		dev.n_load = 0;
		for (int i = 0; i <= c; i++) bus(1'h1, 8'h80 + 8'(4 * i), 32'(16'hC3A0 + 16'(i * 7)));
		bus(1'h1, flash_prog_pkg::REG_START, 32'(s));
		bus(1'h1, flash_prog_pkg::REG_COUNT, 32'(c));
		bus(1'h1, flash_prog_pkg::REG_CTRL, {30'h0, x8, 1'h1});
		poll;
		chk(q, {8'h00, 8'h80, 8'h80 | e, 3'h0, al, 1'h0, e != 8'h00, 2'h2});
		chk(dev.n_data, c + 1);
		chk(dev.n_load, dn + 1);
		for (int i = 0; i <= c; i++) chk(dev.mem[s[5:0] + i] & m, (16'hC3A0 + 16'(i * 7)) & m);
		chk(dev.st, 0);
		chk(byte_n, !x8);
	endtask : run
	// ********
	// Tests
	// ********
	always @(posedge clk_i) begin
		cyc_n++;
		if (cyc_n == 60000) begin
			err_total++;
			end_of_test;
		end
	end
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'h0;
		@(posedge clk_i);
		bus(1'h0, flash_prog_pkg::REG_STATUS, 32'h0);
		chk(q, 32'h0);
		bus(1'h0, 8'h40, 32'h0);
		chk(q, 32'h0);
		run(1'h0, 5'h0F, 24'h010000, 8'h00, 1);
		run(1'h0, 5'h03, 24'h015600, 8'h00, 0);
		for (k = 0; k < 5; k++) run(1'h1, 5'h1F, 24'h020000, errs[k], 0);
		for (k = 0; k < 2; k++) begin
			nw0 = dev.nw;
			bus(1'h1, flash_prog_pkg::REG_START, (k == 0) ? 32'h01FFF8 : 32'h010000);
			bus(1'h1, flash_prog_pkg::REG_COUNT, (k == 0) ? 32'h0F : 32'h10);
			bus(1'h1, flash_prog_pkg::REG_CTRL, 32'h1);
			poll;
			chk(q[7:0], 8'h0E);
			chk(dev.nw, nw0);
		end
		end_of_test;
	end
endmodule : testbench
